// >>> hsfs_pkg.sv
/*
 hsfs_pkg: constants, command codes, status bit positions and carrier
 types of the hot-swap fault supervisor.
 Assumes a 125 MHz single clock; analog comparators live outside.
*/
// Contract
// - undervoltage holds gate off via strong pulldown
// - undervoltage hysteresis sink on while undervoltage present
// - gate source only after insertion interval done
// - undervoltage after insertion interval done sets status flags and alert unless masked
// - overvoltage holds gate off, hysteresis source on
// - gate re-enabled once overvoltage clears
// - overvoltage sets status flags and alert unless masked
// - feedback low forces power-good low
// - power-good released 100 us after all good
// - feedback hysteresis source on while power-good released
// - power-good pulled low 10 us after any loss
// - power-good state readable in status and diagnostic
// - reference pulled low relatches address, resets registers
// - three diode excitation levels sequenced and measured
// - temperature read command returns latest result
// - temperature limits reset to 16'h0100, host rewritable
// - over-temperature fault latches gate off, reports status
// - shorted transistor checked at insertion interval end
// - shorted transistor sets flags and alert unless masked
// - degraded transistor checked only while power-good released
// - degraded persisting 100 ms faults and latches off
// - regulation suppresses degraded check, resets timer
// - default-configuration bit stays until clear-faults
package hsfs_pkg;

  localparam int CLK_MHZ      = 125;
  localparam int TICK_US      = 1;
  localparam int TICK_CYC     = TICK_US * CLK_MHZ;
  localparam int PG_ON_US     = 100;
  localparam int PG_OFF_US    = 10;
  localparam int FETBAD_MS    = 100;
  localparam int FETBAD_US    = FETBAD_MS * 1000;
  localparam int TEMP_STEP_US = 1000;

  localparam logic [7:0] CMD_CLEAR     = 8'h03;
  localparam logic [7:0] CMD_OT_FAULT  = 8'h4F;
  localparam logic [7:0] CMD_OT_WARN   = 8'h51;
  localparam logic [7:0] CMD_STAT_BYTE = 8'h78;
  localparam logic [7:0] CMD_STAT_WORD = 8'h79;
  localparam logic [7:0] CMD_STAT_IN   = 8'h7C;
  localparam logic [7:0] CMD_STAT_TEMP = 8'h7D;
  localparam logic [7:0] CMD_STAT_MFR  = 8'h80;
  localparam logic [7:0] CMD_TEMP      = 8'h8D;
  localparam logic [7:0] CMD_MASK      = 8'hD8;
  localparam logic [7:0] CMD_DIAG      = 8'hE1;

  // sticky flag indices, shared by mask bits
  localparam int F_UV    = 0;
  localparam int F_OV    = 1;
  localparam int F_OTW   = 2;
  localparam int F_OTF   = 3;
  localparam int F_SHORT = 4;
  localparam int F_FETF  = 5;
  localparam int NFLAG   = 6;

  localparam int SW_TEMP = 2;
  localparam int SW_PGN  = 11;
  localparam int SW_MFR  = 12;
  localparam int SW_IN   = 13;
  localparam int SB_UV   = 3;
  localparam int SB_TEMP = 2;
  localparam int SI_OV   = 7;
  localparam int SI_UV   = 4;
  localparam int ST_OTF  = 7;
  localparam int ST_OTW  = 6;
  localparam int SM_SH   = 7;
  localparam int SM_FETF = 6;
  localparam int DG_PG   = 6;
  localparam int DG_CFG  = 7;
  localparam int DG_LAT  = 8;

  localparam logic [15:0]      OT_LIMIT_RST = 16'h0100;
  localparam logic [NFLAG-1:0] MASK_RST     = 6'h00;

  typedef enum logic [3:0] {
    PG_LOW  = 4'b0001,
    PG_RISE = 4'b0010,
    PG_HIGH = 4'b0100,
    PG_FALL = 4'b1000
  } hsfs_pg_t;

  typedef struct packed {
    logic       uv_below;
    logic       ov_above;
    logic       fb_above;
    logic       gate_high;
    logic       sense_over;
    logic       vds_low;
    logic       gate_over;
    logic       vds_high;
    logic       regulating;
    logic       insert_done;
    logic       ref_low;
    logic       restart;
    logic [2:0] addr;
  } hsfs_pins_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } hsfs_cmd_t;

  typedef struct packed {
    logic gate_pulldown;
    logic gate_source;
    logic uv_sink;
    logic ov_source;
    logic fb_source;
  } hsfs_drive_t;

endpackage : hsfs_pkg

// >>> hsfs_sync.sv
/*
 hsfs_sync: two-flop synchroniser for a vector of pin levels.
 Assumes each bit is an independent slow level.
*/
`timescale 1ns/1ps
module hsfs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } hsfs_sync_st_t;

  hsfs_sync_st_t s_q;
  hsfs_sync_st_t s_d;

  always_comb begin
    s_d.s1 = din;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.s2;
endmodule : hsfs_sync

// >>> hsfs_temp_seq.sv
/*
 hsfs_temp_seq: steps the diode excitation through three levels,
 starts one conversion per level and forms the temperature code.
 Assumes an external converter answering adc_start with adc_done.
*/
`timescale 1ns/1ps
module hsfs_temp_seq #(
  parameter int STEP_TICKS = hsfs_pkg::TEMP_STEP_US
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        tick,
  input  wire logic        adc_done,
  input  wire logic [11:0] adc_code,
  output logic      [2:0]  exc_level,
  output logic             adc_start,
  output logic      [15:0] temp_code,
  output logic             temp_valid
);
  import hsfs_pkg::*;

  typedef struct packed {
    logic [2:0]  lvl;
    logic [11:0] wait_cnt;
    logic        busy;
    logic        start;
    logic [11:0] v_lo;
    logic [15:0] temp;
    logic        valid;
  } hsfs_ts_st_t;

  hsfs_ts_st_t s_q;
  hsfs_ts_st_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    if (!s_q.busy) begin
      if (tick) begin
        s_d.wait_cnt = s_q.wait_cnt + 12'h001;
      end
      if (s_q.wait_cnt == 12'(STEP_TICKS - 1)) begin
        s_d.wait_cnt = '0;
        s_d.busy     = 1'b1;
        s_d.start    = 1'b1;
      end
    end else if (adc_done) begin
      s_d.busy = 1'b0;
      // lowest level kept as base; top level minus base gives the code
      if (s_q.lvl[0]) begin
        s_d.v_lo = adc_code;
      end
      if (s_q.lvl[2]) begin
        s_d.temp  = {4'h0, adc_code - s_q.v_lo};
        s_d.valid = 1'b1;
      end
      s_d.lvl = {s_q.lvl[1:0], s_q.lvl[2]};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q     <= '0;
      s_q.lvl <= 3'h1;
    end else begin
      s_q <= s_d;
    end
  end

  assign exc_level  = s_q.lvl;
  assign adc_start  = s_q.start;
  assign temp_code  = s_q.temp;
  assign temp_valid = s_q.valid;
endmodule : hsfs_temp_seq

// >>> hsfs_supervisor.sv
/*
 hsfs_supervisor: supervisory logic of the hot-swap controller.
 Combines comparator levels, temperature and transistor checks into
 gate and hysteresis enables, delayed power-good, sticky status and
 an open-drain alert; host command port returns status words.
 Assumes comparator and pin levels are asynchronous to clk.
*/
`timescale 1ns/1ps
module hsfs_supervisor #(
  parameter int PG_ON_TICKS  = hsfs_pkg::PG_ON_US,
  parameter int FETBAD_TICKS = hsfs_pkg::FETBAD_US,
  parameter int TEMP_TICKS   = hsfs_pkg::TEMP_STEP_US
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire hsfs_pkg::hsfs_pins_t pins,
  input  wire hsfs_pkg::hsfs_cmd_t  cmd,
  input  wire logic               adc_done,
  input  wire logic [11:0]        adc_code,
  output hsfs_pkg::hsfs_drive_t   drive,
  output logic [2:0]              exc_level,
  output logic                    adc_start,
  output logic                    power_good_out_o,
  output logic                    power_good_out_oe,
  output logic                    alert_line_n_o,
  output logic                    alert_line_n_oe,
  output logic [2:0]              bus_addr,
  output logic [15:0]             cmd_rdata,
  output logic                    cmd_ack,
  output logic                    cmd_err
);
  import hsfs_pkg::*;

  ////////////////////////////////////////////////////////////////////

  typedef struct packed {
    hsfs_pg_t         pg;
    logic [6:0]       pg_cnt;
    logic [6:0]       div;
    logic             tick;
    logic [16:0]      bad_cnt;
    logic [NFLAG-1:0] flags;
    logic [NFLAG-1:0] mask;
    logic             cfg_preset;
    logic             latched;
    logic [15:0]      ot_warn;
    logic [15:0]      ot_fault;
    logic [2:0]       addr;
    logic             ins_d;
    logic [1:0]       live;
    logic             alert;
    hsfs_drive_t      drv;
    logic [15:0]      rdata;
    logic             ack;
    logic             err;
  } hsfs_st_t;

  localparam hsfs_st_t ST_RST = '{
    pg:         PG_LOW,
    pg_cnt:     7'h00,
    div:        7'h00,
    tick:       1'b0,
    bad_cnt:    17'h00000,
    flags:      '0,
    mask:       MASK_RST,
    cfg_preset: 1'b1,
    latched:    1'b0,
    ot_warn:    OT_LIMIT_RST,
    ot_fault:   OT_LIMIT_RST,
    addr:       3'h0,
    ins_d:      1'b0,
    live:       2'h0,
    alert:      1'b0,
    drv:        5'h10,
    rdata:      16'h0000,
    ack:        1'b0,
    err:        1'b0
  };

  localparam int PG_OFF_TICKS = PG_OFF_US;

  hsfs_st_t   s_q;
  hsfs_st_t   s_d;
  hsfs_pins_t p;
  logic [15:0] temp_code;
  logic        temp_valid;

  ////////////////////////////////////////////////////////////////////
  // every comparator and strap level crosses two flops first

  hsfs_sync #(
    .W ($bits(hsfs_pins_t))
  ) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (pins),
    .dout (p)
  );

  hsfs_temp_seq #(
    .STEP_TICKS (TEMP_TICKS)
  ) u_temp (
    .clk        (clk),
    .rst        (rst),
    .tick       (s_q.tick),
    .adc_done   (adc_done),
    .adc_code   (adc_code),
    .exc_level  (exc_level),
    .adc_start  (adc_start),
    .temp_code  (temp_code),
    .temp_valid (temp_valid)
  );

  ////////////////////////////////////////////////////////////////////

  logic             pg_good;
  logic             all_good;
  logic             any_fault;
  logic             ot_f;
  logic             ot_w;
  logic             bad_now;
  logic             short_now;
  logic             gate_ok;
  logic [NFLAG-1:0] set_v;
  logic [NFLAG-1:0] clr_v;
  logic [15:0]      sword;
  logic [15:0]      diag;

  always_comb begin
    s_d = s_q;
    set_v = '0;
    clr_v = '0;

    // 1 us enable pulse for all slow timers
    s_d.tick = 1'b0;
    s_d.div  = s_q.div + 7'h01;
    if (s_q.div == 7'(TICK_CYC - 1)) begin
      s_d.div  = 7'h00;
      s_d.tick = 1'b1;
    end

    pg_good = (s_q.pg == PG_HIGH) || (s_q.pg == PG_FALL);

    // temperature limits compare only once a result exists
    ot_f = temp_valid && (temp_code >= s_q.ot_fault);
    ot_w = temp_valid && (temp_code >= s_q.ot_warn);

    // shorted pass transistor sampled on insertion interval end
    short_now = p.insert_done && !s_q.ins_d &&
                s_q.drv.gate_pulldown && (p.sense_over || p.vds_low);
    s_d.ins_d = p.insert_done;

    bad_now = pg_good && !p.regulating &&
              (p.gate_over || p.vds_high);

    ////////////////////////////////////////////////////////////////
    // persistence timer for degraded transistor

    if (!bad_now) begin
      s_d.bad_cnt = 17'h00000;
    end else if (s_q.tick) begin
      s_d.bad_cnt = s_q.bad_cnt + 17'h00001;
    end
    if (bad_now && s_q.bad_cnt == 17'(FETBAD_TICKS)) begin
      set_v[F_FETF] = 1'b1;
      s_d.bad_cnt = 17'h00000;
    end

    set_v[F_UV]    = p.uv_below && (s_q.live == 2'h3) && p.insert_done;
    set_v[F_OV]    = p.ov_above && (s_q.live == 2'h3);
    set_v[F_OTW]   = ot_w;
    set_v[F_OTF]   = ot_f;
    set_v[F_SHORT] = short_now;

    ////////////////////////////////////////////////////////////////
    // latch-off: cleared only by a manual restart

    if (p.restart) begin
      s_d.latched = 1'b0;
    end
    if (ot_f || short_now || set_v[F_FETF]) begin
      s_d.latched = 1'b1;
    end

    any_fault = s_q.latched || s_q.flags[F_OTF] ||
                s_q.flags[F_FETF];

    ////////////////////////////////////////////////////////////////
    // gate and hysteresis drives

    gate_ok = p.insert_done && !p.uv_below && !p.ov_above &&
              !s_q.latched;
    s_d.drv.gate_source   = gate_ok;
    s_d.drv.gate_pulldown = !gate_ok;
    s_d.drv.uv_sink       = p.uv_below;
    s_d.drv.ov_source     = p.ov_above;

    ////////////////////////////////////////////////////////////////
    // power-good delay machine

    all_good = p.fb_above && p.gate_high && !p.uv_below &&
               !p.ov_above && !any_fault;
    unique case (s_q.pg)
      PG_LOW: begin
        s_d.pg_cnt = 7'h00;
        if (all_good) begin
          s_d.pg = PG_RISE;
        end
      end
      PG_RISE: begin
        if (!all_good) begin
          s_d.pg = PG_LOW;
        end else if (s_q.pg_cnt == 7'(PG_ON_TICKS - 1) && s_q.tick) begin
          s_d.pg = PG_HIGH;
        end else if (s_q.tick) begin
          s_d.pg_cnt = s_q.pg_cnt + 7'h01;
        end
      end
      PG_HIGH: begin
        s_d.pg_cnt = 7'h00;
        if (!all_good || set_v[F_FETF]) begin
          s_d.pg = PG_FALL;
        end
      end
      PG_FALL: begin
        if (s_q.pg_cnt == 7'(PG_OFF_TICKS - 1) && s_q.tick) begin
          s_d.pg = PG_LOW;
        end else if (s_q.tick) begin
          s_d.pg_cnt = s_q.pg_cnt + 7'h01;
        end
      end
    endcase
    s_d.drv.fb_source = (s_d.pg == PG_HIGH) || (s_d.pg == PG_FALL);

    ////////////////////////////////////////////////////////////////
    // status words

    sword = 16'h0000;
    sword[SW_IN]   = s_q.flags[F_UV] || s_q.flags[F_OV];
    sword[SW_PGN]  = !pg_good;
    sword[SW_MFR]  = s_q.flags[F_SHORT] || s_q.flags[F_FETF];
    sword[SW_TEMP] = s_q.flags[F_OTW] || s_q.flags[F_OTF];

    diag = 16'h0000;
    diag[NFLAG-1:0] = s_q.flags;
    diag[DG_PG]     = pg_good;
    diag[DG_CFG]    = s_q.cfg_preset;
    diag[DG_LAT]    = s_q.latched;

    ////////////////////////////////////////////////////////////////
    // host command port: one answer the cycle after each request

    s_d.ack   = cmd.valid;
    s_d.err   = 1'b0;
    s_d.rdata = 16'h0000;
    if (cmd.valid) begin
      unique case (cmd.code)
        CMD_CLEAR: begin
          clr_v = '1;
          s_d.cfg_preset = 1'b0;
        end
        CMD_OT_FAULT: begin
          if (cmd.write) begin
            s_d.ot_fault = cmd.wdata;
          end
          s_d.rdata = s_q.ot_fault;
        end
        CMD_OT_WARN: begin
          if (cmd.write) begin
            s_d.ot_warn = cmd.wdata;
          end
          s_d.rdata = s_q.ot_warn;
        end
        CMD_MASK: begin
          if (cmd.write) begin
            s_d.mask = cmd.wdata[NFLAG-1:0];
          end
          s_d.rdata = {10'h000, s_q.mask};
        end
        CMD_STAT_BYTE: begin
          s_d.rdata[SB_UV]   = s_q.flags[F_UV];
          s_d.rdata[SB_TEMP] = sword[SW_TEMP];
        end
        CMD_STAT_WORD: s_d.rdata = sword;
        CMD_STAT_IN: begin
          s_d.rdata[SI_OV] = s_q.flags[F_OV];
          s_d.rdata[SI_UV] = s_q.flags[F_UV];
        end
        CMD_STAT_TEMP: begin
          s_d.rdata[ST_OTF] = s_q.flags[F_OTF];
          s_d.rdata[ST_OTW] = s_q.flags[F_OTW];
        end
        CMD_STAT_MFR: begin
          s_d.rdata[SM_SH]   = s_q.flags[F_SHORT];
          s_d.rdata[SM_FETF] = s_q.flags[F_FETF];
        end
        CMD_TEMP: s_d.rdata = temp_code;
        CMD_DIAG: s_d.rdata = diag;
        default: s_d.err = 1'b1;
      endcase
    end

    // a new event beats a clear in the same cycle
    s_d.flags = (s_q.flags & ~clr_v) | set_v;

    ////////////////////////////////////////////////////////////////
    // reference pulled low: relatch address, registers to defaults

    // sync flops hold reset zeros for two edges; strap trusted after that
    s_d.live = s_q.live + 2'(s_q.live != 2'h3);
    if ((s_q.live != 2'h3) || p.ref_low) begin
      s_d.addr = p.addr;
    end
    if (p.ref_low) begin
      s_d.flags      = '0;
      s_d.mask       = MASK_RST;
      s_d.ot_warn    = OT_LIMIT_RST;
      s_d.ot_fault   = OT_LIMIT_RST;
      s_d.cfg_preset = 1'b1;
    end

    // alert is a level held while any unmasked flag stands
    s_d.alert = |(s_d.flags & ~s_d.mask);
  end

  ////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // open-drain pins only ever pull low

  assign drive             = s_q.drv;
  assign power_good_out_o  = 1'b0;
  assign power_good_out_oe = !((s_q.pg == PG_HIGH) || (s_q.pg == PG_FALL));
  assign alert_line_n_o    = 1'b0;
  assign alert_line_n_oe   = s_q.alert;
  assign bus_addr          = s_q.addr;
  assign cmd_rdata         = s_q.rdata;
  assign cmd_ack           = s_q.ack;
  assign cmd_err           = s_q.err;

endmodule : hsfs_supervisor

// >>> hsfs_supervisor_asserts.sv
/*
 hsfs_supervisor_asserts: port-level checker for hsfs_supervisor.
 Assumes pin levels are held several cycles, as the bench does.
*/
`timescale 1ns/1ps
module hsfs_supervisor_asserts (
  input wire logic                 clk,
  input wire logic                 rst,
  input wire hsfs_pkg::hsfs_pins_t  pins,
  input wire hsfs_pkg::hsfs_cmd_t   cmd,
  input wire hsfs_pkg::hsfs_drive_t drive,
  input wire logic [2:0]           exc_level,
  input wire logic                 adc_start,
  input wire logic                 power_good_out_oe,
  input wire logic [15:0]          cmd_rdata,
  input wire logic                 cmd_ack,
  input wire logic                 cmd_err
);
  import hsfs_pkg::*;
  function automatic logic known(input logic [7:0] c);
    return c inside {CMD_CLEAR, CMD_OT_FAULT, CMD_OT_WARN, CMD_STAT_BYTE, CMD_STAT_WORD,
                     CMD_STAT_IN, CMD_STAT_TEMP, CMD_STAT_MFR, CMD_TEMP, CMD_MASK, CMD_DIAG};
  endfunction : known
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // five samples cover two sync flops plus the output register
  sequence uv_held; pins.uv_below [*5]; endsequence
  sequence uv_gone; !pins.uv_below [*5]; endsequence
  sequence ov_held; pins.ov_above [*5]; endsequence
  ////////////////////////////////////////////////////////////////////////////
  chk_uv_gate_off: assert property (uv_held |-> drive.gate_pulldown && !drive.gate_source)
    else $error("gate not held off while undervoltage");
  chk_uv_sink_on: assert property (uv_held |-> drive.uv_sink)
    else $error("undervoltage sink off while undervoltage");
  chk_uv_sink_off: assert property (uv_gone |-> !drive.uv_sink)
    else $error("undervoltage sink on after recovery");
  chk_ov_hold_off: assert property (ov_held |-> drive.gate_pulldown && drive.ov_source)
    else $error("overvoltage did not hold gate off");
  chk_gate_one_way: assert property (!(drive.gate_pulldown && drive.gate_source))
    else $error("gate source and pulldown both on");
  chk_pg_release_cause: assert property ($fell(power_good_out_oe) |->
    $past(pins.fb_above, 4) && $past(pins.gate_high, 4) && !$past(pins.uv_below, 4))
    else $error("power good released without cause");
  chk_fb_source_on: assert property (!power_good_out_oe && !$past(power_good_out_oe)
    |-> drive.fb_source)
    else $error("feedback source off while power good");
  chk_cmd_answer: assert property (cmd.valid |=> cmd_ack)
    else $error("command not acknowledged");
  chk_ack_cause: assert property (cmd_ack |-> $past(cmd.valid))
    else $error("acknowledge without command");
  chk_unknown_refused: assert property (cmd.valid && !known(cmd.code)
    |=> cmd_err && cmd_rdata == 16'h0000)
    else $error("unknown command not refused");
  chk_exc_one_hot: assert property ($onehot(exc_level))
    else $error("excitation level not one-hot");
  chk_start_pulse: assert property (adc_start |=> !adc_start)
    else $error("conversion start longer than one cycle");
endmodule : hsfs_supervisor_asserts
bind hsfs_supervisor hsfs_supervisor_asserts u_chk (.clk(clk), .rst(rst), .pins(pins),
  .cmd(cmd), .drive(drive), .exc_level(exc_level), .adc_start(adc_start),
  .power_good_out_oe(power_good_out_oe), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack),
  .cmd_err(cmd_err));

// >>> hsfs_adc_model.sv
/*
 hsfs_adc_model: converter behind the diode pin, answers each start
 with a done pulse; code depends on the excitation level.
 Assumes exc_level is steady from start to done.
*/
`timescale 1ns/1ps
module hsfs_adc_model #(
  parameter logic [11:0] C_LO = 12'h040,
  parameter logic [11:0] C_MD = 12'h090,
  parameter logic [11:0] C_HI = 12'h0E0
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        adc_start,
  input  wire logic [2:0]  exc_level,
  output logic             adc_done,
  output logic      [11:0] adc_code
);
  logic [1:0] cnt;
  // code is only valid with done; otherwise it keeps toggling
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 2'h0;
      adc_done <= 1'b0;
      adc_code <= 12'h000;
    end else begin
      cnt <= adc_start ? 2'h3 : (cnt != 2'h0 ? cnt - 2'h1 : 2'h0);
      adc_done <= (cnt == 2'h1);
      adc_code <= (cnt == 2'h1) ? (exc_level[2] ? C_HI : exc_level[1] ? C_MD : C_LO) : ~adc_code;
    end
  end
endmodule : hsfs_adc_model

// >>> hsfs_supervisor_bench.sv
/*
 hsfs_supervisor_bench: self-checking bench for hsfs_supervisor.
 Assumes shortened tick counts and a 1 us tick of 125 clocks.
*/
`timescale 1ns/1ps
module hsfs_supervisor_bench;
  import hsfs_pkg::*;
  localparam int          TK = 125;
  localparam logic [11:0] LO = 12'h040;
  localparam logic [11:0] HI = 12'h0E0;
  logic        clk, rst, adc_done, adc_start, pg_oe, al_oe, ack, err, e;
  hsfs_pins_t  pins;
  hsfs_cmd_t   cmd;
  hsfs_drive_t drive;
  logic [11:0] adc_code;
  logic [2:0]  exc_level, bus_addr, a;
  logic [15:0] rdata, r, d;
  logic [7:0]  lim [2];
  integer      seed, error_cnt, compares;
  hsfs_supervisor #(.PG_ON_TICKS(5), .FETBAD_TICKS(20), .TEMP_TICKS(4)) DUT (.clk(clk),
    .rst(rst), .pins(pins), .cmd(cmd), .adc_done(adc_done), .adc_code(adc_code),
    .drive(drive), .exc_level(exc_level), .adc_start(adc_start), .power_good_out_o(),
    .power_good_out_oe(pg_oe), .alert_line_n_o(), .alert_line_n_oe(al_oe),
    .bus_addr(bus_addr), .cmd_rdata(rdata), .cmd_ack(ack), .cmd_err(err));
  hsfs_adc_model #(.C_LO(LO), .C_HI(HI)) adc (.clk(clk), .rst(rst), .adc_start(adc_start),
    .exc_level(exc_level), .adc_done(adc_done), .adc_code(adc_code));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] exp_temp();
    return {4'h0, HI - LO};
  endfunction : exp_temp
  task automatic stop_test();
    $display("compares %0d, errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic op(input logic w, input logic [7:0] c, input logic [15:0] v);
    cmd <= '{1'b1, w, c, v};
    @(negedge clk);
    chk(ack, 1'b1);
    r = rdata;
    e = err;
    cmd.valid <= 1'b0;
    @(negedge clk);
  endtask : op
  task automatic rdb(input logic [7:0] c, input int b, input logic x);
    op(1'b0, c, 16'h0000);
    chk(r[b], x);
  endtask : rdb
  task automatic wait_oe(input logic v, input int n);
    for (int i = 0; i < n && pg_oe !== v; i++) @(negedge clk);
    if (pg_oe !== v) begin
      error_cnt++;
      $display("unexpected at %0t: power good wait ran out", $time);
      stop_test();
    end
  endtask : wait_oe
  task automatic recover();
    pins.restart = 1'b1;
    cyc(4);
    pins.restart = 1'b0;
    cyc(6);
    op(1'b1, CMD_CLEAR, 16'h0000);
    cyc(3);
  endtask : recover
  task automatic fin(input string s);
    $display("test %s done", s);
  endtask : fin
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #400000;
    error_cnt++;
    $display("unexpected at %0t: run limit reached", $time);
    stop_test();
  end
  initial begin
    seed = 32'hE8BF;
    error_cnt = 0;
    compares = 0;
    lim = '{CMD_OT_FAULT, CMD_OT_WARN};
    pins = '0;
    cmd = '0;
    rst = 1'b1;
    a = 3'($random(seed));
    pins.addr = a;
    cyc(5);
    chk({11'h000, drive}, 16'h0010);
    rst = 1'b0;
    cyc(3);
    chk({11'h000, drive}, 16'h0010);
    chk(pg_oe, 1'b1);
    chk(bus_addr, a);
    rdb(CMD_DIAG, DG_CFG, 1'b1);
    foreach (lim[i]) begin
      op(1'b0, lim[i], 16'h0000);
      chk(r, OT_LIMIT_RST);
      d = 16'($random(seed)) | 16'h0100;
      op(1'b1, lim[i], d);
      op(1'b0, lim[i], 16'h0000);
      chk(r, d);
    end
    op(1'b0, 8'h55, 16'h0000);
    chk(e, 1'b1);
    chk(r, 16'h0000);
    fin("reset");
    pins.sense_over = 1'b1;
    cyc(2);
    pins.insert_done = 1'b1;
    cyc(8);
    rdb(CMD_STAT_MFR, SM_SH, 1'b1);
    rdb(CMD_DIAG, F_SHORT, 1'b1);
    chk({al_oe, drive.gate_source}, 2'h2);
    pins.sense_over = 1'b0;
    pins.restart = 1'b1;
    cyc(4);
    pins.restart = 1'b0;
    cyc(6);
    rdb(CMD_STAT_MFR, SM_SH, 1'b1);
    recover();
    chk({al_oe, drive.gate_source}, 2'h1);
    rdb(CMD_DIAG, DG_CFG, 1'b0);
    fin("short");
    pins.uv_below = 1'b1;
    cyc(6);
    chk({drive.gate_pulldown, drive.uv_sink, drive.gate_source}, 3'h6);
    rdb(CMD_STAT_BYTE, SB_UV, 1'b1);
    rdb(CMD_STAT_IN, SI_UV, 1'b1);
    rdb(CMD_DIAG, F_UV, 1'b1);
    rdb(CMD_STAT_WORD, SW_IN, 1'b1);
    chk(al_oe, 1'b1);
    op(1'b1, CMD_MASK, 16'($random(seed)) | 16'h0001);
    cyc(2);
    chk(al_oe, 1'b0);
    pins.uv_below = 1'b0;
    cyc(6);
    chk({drive.uv_sink, drive.gate_source}, 2'h1);
    op(1'b1, CMD_MASK, 16'h0000);
    recover();
    fin("undervoltage");
    pins.ov_above = 1'b1;
    cyc(6);
    chk({drive.gate_pulldown, drive.ov_source}, 2'h3);
    rdb(CMD_STAT_IN, SI_OV, 1'b1);
    rdb(CMD_DIAG, F_OV, 1'b1);
    rdb(CMD_STAT_WORD, SW_IN, 1'b1);
    chk(al_oe, 1'b1);
    pins.ov_above = 1'b0;
    cyc(6);
    chk({drive.ov_source, drive.gate_source}, 2'h1);
    recover();
    fin("overvoltage");
    pins.fb_above = 1'b1;
    pins.gate_high = 1'b1;
    cyc(4 * TK);
    chk(pg_oe, 1'b1);
    wait_oe(1'b0, 3 * TK);
    cyc(2);
    chk(drive.fb_source, 1'b1);
    rdb(CMD_STAT_WORD, SW_PGN, 1'b0);
    rdb(CMD_DIAG, DG_PG, 1'b1);
    pins.regulating = 1'b1;
    pins.vds_high = 1'b1;
    cyc(25 * TK);
    chk(pg_oe, 1'b0);
    pins.regulating = 1'b0;
    cyc(27 * TK);
    chk(pg_oe, 1'b0);
    wait_oe(1'b1, 6 * TK);
    rdb(CMD_STAT_MFR, SM_FETF, 1'b1);
    chk({al_oe, drive.gate_source}, 2'h2);
    pins.vds_high = 1'b0;
    recover();
    wait_oe(1'b0, 8 * TK);
    pins.fb_above = 1'b0;
    cyc(8 * TK);
    chk(pg_oe, 1'b0);
    wait_oe(1'b1, 4 * TK);
    cyc(2);
    chk(drive.fb_source, 1'b0);
    fin("power good");
    op(1'b0, CMD_TEMP, 16'h0000);
    chk(r, exp_temp());
    op(1'b1, CMD_OT_FAULT, exp_temp());
    op(1'b1, CMD_OT_WARN, exp_temp() - 16'h0001);
    cyc(16 * TK);
    rdb(CMD_STAT_TEMP, ST_OTF, 1'b1);
    rdb(CMD_STAT_TEMP, ST_OTW, 1'b1);
    rdb(CMD_DIAG, F_OTF, 1'b1);
    rdb(CMD_STAT_WORD, SW_TEMP, 1'b1);
    chk(drive.gate_source, 1'b0);
    fin("temperature");
    a = 3'($random(seed));
    pins.addr = a;
    cyc(4);
    pins.ref_low = 1'b1;
    cyc(4);
    pins.ref_low = 1'b0;
    cyc(4);
    chk(bus_addr, a);
    op(1'b0, CMD_OT_FAULT, 16'h0000);
    chk(r, OT_LIMIT_RST);
    rdb(CMD_STAT_TEMP, ST_OTF, 1'b0);
    rdb(CMD_DIAG, DG_CFG, 1'b1);
    op(1'b1, CMD_CLEAR, 16'h0000);
    rdb(CMD_DIAG, DG_CFG, 1'b0);
    fin("soft reset");
    stop_test();
  end
endmodule : hsfs_supervisor_bench
